// ---- asm_defs.svh ----
/*
  Constants of the cipher security module: register offsets, bit positions,
  reset values and round figures. Assumes an 8-bit register port with a
  9-bit byte address and one 25 MHz system clock.
*/
`ifndef ASM_DEFS_SVH
`define ASM_DEFS_SVH

`define ASM_ADDR_W        9
`define ASM_OFF_CTRL      9'h13C
`define ASM_OFF_STATUS    9'h13D
`define ASM_OFF_TEXT      9'h13E
`define ASM_OFF_KEY       9'h13F
`define ASM_OFF_MASK      9'h140

`define ASM_CTRL_REQ      7
`define ASM_CTRL_MODE     5
`define ASM_CTRL_DIR      3
`define ASM_CTRL_IE       2
`define ASM_STAT_ERR      7
`define ASM_STAT_DONE     0

`define ASM_MASK_RST      8'hFF
`define ASM_RCON_FIRST    8'h01
`define ASM_RCON_LAST     8'h36
`define ASM_ROUNDS        4'hA
`define ASM_AFFINE_C      8'h63
`define ASM_INV_AFFINE_C  8'h05
`define ASM_POLY          8'h1B

`endif

// ---- asm_pkg.sv ----
/*
  Types of the cipher security module: state codes, register bus carrier
  and the module's complete state record. Assumes asm_defs.svh is present.
*/
package asm_pkg;

  typedef enum logic [1:0] {
    ASM_IDLE = 2'b01,
    ASM_RUN  = 2'b10
  } asm_state_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } asm_bus_t;

  typedef struct packed {
    asm_state_t       st;
    logic [3:0]       rnd;
    logic             mode;
    logic             dir;
    logic             ie;
    logic             done;
    logic             err;
    logic [7:0]       mask;
    logic [15:0][7:0] text;
    logic [127:0]     key;
    logic [127:0]     rk;
    logic [127:0]     s;
    logic [127:0]     blk_in;
    logic [127:0]     chain;
    logic [7:0]       rcon;
    logic [3:0]       tptr;
    logic [3:0]       kptr;
    logic [7:0]       rdata;
    logic             irq;
  } asm_regs_t;

endpackage : asm_pkg

// ---- asm_core.sv ----
/*
  Cipher security module: byte-wide register port, text and key buffers
  loaded by repeated access, iterative AES-128 with one round per cycle,
  code book and chaining modes, sticky status with interrupt.
  Assumes a master that keeps strobes one cycle long and never both at once,
  and a transceiver sleep level on the same clock as the module.
*/
`timescale 1ns/1ps
`include "asm_defs.svh"

module asm_core (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  // Register port
  input  wire asm_pkg::asm_bus_t bus,
  output logic [7:0]            rdata,
  // Transceiver sleep level
  input  wire logic             trx_sleep,
  // Interrupt
  output logic                  irq
);

  asm_pkg::asm_regs_t r;
  asm_pkg::asm_regs_t next_r;

  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? `ASM_POLY : 8'h00);
  endfunction : xt

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    gmul = p;
  endfunction : gmul

  // Inverse by x^254; zero maps to zero as the cipher requires
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] sq;
    logic [7:0] acc;
    sq = a;
    acc = 8'h01;
    for (int i = 0; i < 7; i++) begin
      sq = gmul(sq, sq);
      acc = gmul(acc, sq);
    end
    ginv = acc;
  endfunction : ginv

  function automatic logic [7:0] rotl(input logic [7:0] a, input int n);
    rotl = (a << n) | (a >> (8 - n));
  endfunction : rotl

  // Substitution is computed, not tabled, to keep the design free of ROMs
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    sbox = b ^ rotl(b, 1) ^ rotl(b, 2) ^ rotl(b, 3) ^ rotl(b, 4) ^ `ASM_AFFINE_C;
  endfunction : sbox

  function automatic logic [7:0] isbox(input logic [7:0] a);
    isbox = ginv(rotl(a, 1) ^ rotl(a, 3) ^ rotl(a, 6) ^ `ASM_INV_AFFINE_C);
  endfunction : isbox

  // Byte k of a block sits at bits 127-8k, row k%4, column k/4
  function automatic logic [7:0] gb(input logic [127:0] v, input int k);
    gb = v[127 - 8 * k -: 8];
  endfunction : gb

  function automatic logic [127:0] sub_shift(input logic [127:0] v, input logic inv);
    logic [127:0] o;
    int src;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int rw = 0; rw < 4; rw++) begin
        src = inv ? 4 * ((c + 4 - rw) % 4) + rw : 4 * ((c + rw) % 4) + rw;
        o[127 - 8 * (4 * c + rw) -: 8] = inv ? isbox(gb(v, src)) : sbox(gb(v, src));
      end
    end
    sub_shift = o;
  endfunction : sub_shift

  function automatic logic [127:0] mix(input logic [127:0] v, input logic inv);
    logic [127:0] o;
    logic [7:0] a0;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] a3;
    logic [7:0] m0;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] m3;
    o = '0;
    m0 = inv ? 8'h0E : 8'h02;
    m1 = inv ? 8'h0B : 8'h03;
    m2 = inv ? 8'h0D : 8'h01;
    m3 = inv ? 8'h09 : 8'h01;
    for (int c = 0; c < 4; c++) begin
      a0 = gb(v, 4 * c);
      a1 = gb(v, 4 * c + 1);
      a2 = gb(v, 4 * c + 2);
      a3 = gb(v, 4 * c + 3);
      o[127 - 32 * c -: 32] = {
        gmul(a0, m0) ^ gmul(a1, m1) ^ gmul(a2, m2) ^ gmul(a3, m3),
        gmul(a0, m3) ^ gmul(a1, m0) ^ gmul(a2, m1) ^ gmul(a3, m2),
        gmul(a0, m2) ^ gmul(a1, m3) ^ gmul(a2, m0) ^ gmul(a3, m1),
        gmul(a0, m1) ^ gmul(a1, m2) ^ gmul(a2, m3) ^ gmul(a3, m0)};
    end
    mix = o;
  endfunction : mix

  function automatic logic [31:0] subrot(input logic [31:0] w, input logic [7:0] rc);
    subrot = {sbox(w[23:16]) ^ rc, sbox(w[15:8]), sbox(w[7:0]), sbox(w[31:24])};
  endfunction : subrot

  // Forward and backward key steps; decryption walks back from the last key
  function automatic logic [127:0] key_fwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w0 = k[127:96] ^ subrot(k[31:0], rc);
    w1 = k[95:64] ^ w0;
    w2 = k[63:32] ^ w1;
    w3 = k[31:0] ^ w2;
    key_fwd = {w0, w1, w2, w3};
  endfunction : key_fwd

  function automatic logic [127:0] key_bwd(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w3 = k[31:0] ^ k[63:32];
    w2 = k[63:32] ^ k[95:64];
    w1 = k[95:64] ^ k[127:96];
    key_bwd = {k[127:96] ^ subrot(w3, rc), w1, w2, w3};
  endfunction : key_bwd

  function automatic logic [7:0] rc_back(input logic [7:0] a);
    rc_back = a[0] ? (((a ^ `ASM_POLY) >> 1) | 8'h80) : (a >> 1);
  endfunction : rc_back

  logic acc_ctrl;
  logic acc_stat;
  logic acc_text;
  logic acc_key;
  logic acc_mask;
  logic req_start;
  logic bad_load;

  assign acc_ctrl  = (bus.wr | bus.rd) && bus.addr == `ASM_OFF_CTRL;
  assign acc_stat  = bus.rd && bus.addr == `ASM_OFF_STATUS;
  assign acc_text  = (bus.wr | bus.rd) && bus.addr == `ASM_OFF_TEXT;
  assign acc_key   = (bus.wr | bus.rd) && bus.addr == `ASM_OFF_KEY;
  assign acc_mask  = (bus.wr | bus.rd) && bus.addr == `ASM_OFF_MASK;
  assign req_start = bus.wr && bus.addr == `ASM_OFF_CTRL && bus.wdata[`ASM_CTRL_REQ];
  assign bad_load  = r.tptr != 4'h0 || r.kptr != 4'h0;

  always_comb begin
    logic [127:0] rk_n;
    logic [127:0] res;
    logic         ev_done;
    logic         ev_err;
    rk_n = '0;
    res = '0;
    ev_done = 1'b0;
    ev_err = 1'b0;
    next_r = r;
    next_r.rdata = 8'h00;

    // Status reads clear; an event in the same cycle still sets the flag
    if (acc_stat) begin
      next_r.done = 1'b0;
      next_r.err = 1'b0;
    end

    // Read decode; unmapped addresses answer zero
    if (bus.rd) begin
      if (bus.addr == `ASM_OFF_CTRL) begin
        next_r.rdata = {2'b00, r.mode, 1'b0, r.dir, r.ie, 2'b00};
      end else if (bus.addr == `ASM_OFF_STATUS) begin
        next_r.rdata = {r.err, 6'h00, r.done};
      end else if (bus.addr == `ASM_OFF_TEXT) begin
        next_r.rdata = r.text[~r.tptr];
      end else if (bus.addr == `ASM_OFF_KEY) begin
        next_r.rdata = gb(r.rk, int'(r.kptr));
      end else if (bus.addr == `ASM_OFF_MASK) begin
        next_r.rdata = r.mask;
      end
    end

    // Buffers fill and drain one byte per access through a wrapping pointer
    if (acc_text) begin
      if (bus.wr) next_r.text[~r.tptr] = bus.wdata;
      next_r.tptr = r.tptr + 4'h1;
    end
    if (acc_key) begin
      if (bus.wr) begin
        next_r.key[127 - 8 * int'(r.kptr) -: 8] = bus.wdata;
        next_r.rk[127 - 8 * int'(r.kptr) -: 8] = bus.wdata;
      end
      next_r.kptr = r.kptr + 4'h1;
    end
    if (acc_mask && bus.wr) next_r.mask = bus.wdata;

    case (r.st)
      asm_pkg::ASM_IDLE: begin
        if (bus.wr && bus.addr == `ASM_OFF_CTRL) begin
          next_r.mode = bus.wdata[`ASM_CTRL_MODE];
          next_r.dir = bus.wdata[`ASM_CTRL_DIR];
          next_r.ie = bus.wdata[`ASM_CTRL_IE];
        end
        if (req_start) begin
          if (bad_load) begin
            ev_err = 1'b1;
            next_r.tptr = 4'h0;
            next_r.kptr = 4'h0;
          end else begin
            next_r.st = asm_pkg::ASM_RUN;
            next_r.rnd = 4'h1;
            next_r.blk_in = r.text;
            // Start from the stored key; the visible key may be a round key
            next_r.rk = r.key;
            if (bus.wdata[`ASM_CTRL_DIR]) begin
              next_r.rcon = `ASM_RCON_LAST;
              next_r.s = r.text ^ r.key;
            end else begin
              next_r.rcon = `ASM_RCON_FIRST;
              next_r.s = r.text ^ r.key
                         ^ (bus.wdata[`ASM_CTRL_MODE] ? r.chain : 128'h0);
            end
          end
        end
      end
      asm_pkg::ASM_RUN: begin
        if (acc_ctrl) begin
          // Any control access kills the run; the buffers keep what they had
          next_r.st = asm_pkg::ASM_IDLE;
          ev_err = 1'b1;
        end else begin
          if (r.dir) begin
            rk_n = key_bwd(r.rk, r.rcon);
            res = sub_shift(r.s, 1'b1) ^ rk_n;
            if (r.rnd != `ASM_ROUNDS) res = mix(res, 1'b1);
            next_r.rcon = rc_back(r.rcon);
          end else begin
            rk_n = key_fwd(r.rk, r.rcon);
            res = sub_shift(r.s, 1'b0);
            if (r.rnd != `ASM_ROUNDS) res = mix(res, 1'b0);
            res = res ^ rk_n;
            next_r.rcon = xt(r.rcon);
          end
          next_r.rk = rk_n;
          next_r.s = res;
          next_r.rnd = r.rnd + 4'h1;
          if (r.rnd == `ASM_ROUNDS) begin
            next_r.st = asm_pkg::ASM_IDLE;
            ev_done = 1'b1;
            next_r.tptr = 4'h0;
            next_r.kptr = 4'h0;
            if (r.dir) begin
              next_r.text = res ^ (r.mode ? r.chain : 128'h0);
              if (r.mode) next_r.chain = r.blk_in;
            end else begin
              next_r.text = res;
              next_r.chain = res;
            end
          end
        end
      end
      default: next_r.st = asm_pkg::ASM_IDLE;
    endcase

    if (ev_done) next_r.done = 1'b1;
    if (ev_err) next_r.err = 1'b1;

    // Sleep returns every register of the block to its reset value, key material included
    if (trx_sleep) begin
      next_r = '0;
      next_r.st = asm_pkg::ASM_IDLE;
      next_r.mask = `ASM_MASK_RST;
    end

    next_r.irq = next_r.ie
                 && |({next_r.err, 6'h00, next_r.done} & next_r.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= asm_pkg::ASM_IDLE;
      r.mask <= `ASM_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign irq = r.irq;

  start_run_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_IDLE && req_start && !bad_load && !trx_sleep
    |=> r.st == asm_pkg::ASM_RUN && r.rnd == 4'h1)
    else $error("request did not start a run");

  abort_ctrl_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_RUN && acc_ctrl && !trx_sleep
    |=> r.st == asm_pkg::ASM_IDLE && r.err && r.done == $past(r.done))
    else $error("control access did not abort the run");

  sleep_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    trx_sleep |=> r.text == '0 && r.key == '0 && !r.done && !r.err && !r.mode && !r.ie)
    else $error("sleep left state behind");

  mode_dir_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_IDLE && bus.wr && bus.addr == `ASM_OFF_CTRL && !trx_sleep
    |=> r.mode == $past(bus.wdata[5]) && r.dir == $past(bus.wdata[3]))
    else $error("mode or direction not taken");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq |-> r.ie && (r.done || r.err))
    else $error("interrupt without enable or cause");

  bad_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_IDLE && req_start && bad_load && !trx_sleep
    |=> r.st == asm_pkg::ASM_IDLE && r.err)
    else $error("partial buffer not flagged");

  run_length_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(r.st == asm_pkg::ASM_RUN) ##0 (!acc_ctrl && !trx_sleep) [*8]
    ##1 (!acc_ctrl && !trx_sleep) [*2] |=> r.done && r.st == asm_pkg::ASM_IDLE)
    else $error("run did not finish in ten rounds");

  text_ptr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_IDLE && acc_text && !req_start && !trx_sleep
    |=> r.tptr == $past(r.tptr) + 4'h1)
    else $error("text pointer did not advance");

  key_keep_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_RUN && !acc_key && !trx_sleep |=> $stable(r.key))
    else $error("stored key changed during run");

  key_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    bus.rd && bus.addr == `ASM_OFF_KEY && !trx_sleep
    |=> rdata == $past(r.rk[127 - 8 * int'(r.kptr) -: 8]))
    else $error("key read not from round key");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq |-> |({r.err, 6'h00, r.done} & r.mask))
    else $error("interrupt from a masked flag");

  // The result of a chained encryption must seed the next block
  chain_enc_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_RUN && r.rnd == `ASM_ROUNDS && !r.dir && !acc_ctrl && !trx_sleep
    |=> r.chain == r.text)
    else $error("chaining value not taken from the result");

  ptr_end_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    r.st == asm_pkg::ASM_RUN && r.rnd == `ASM_ROUNDS && !acc_ctrl && !trx_sleep
    |=> r.tptr == 4'h0 && r.kptr == 4'h0)
    else $error("buffer pointers not rewound at run end");

  // In idle no event can meet a status read, so the read must leave both flags clear
  stat_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    acc_stat && r.st == asm_pkg::ASM_IDLE |=> !r.done && !r.err)
    else $error("status read did not clear the flags");

endmodule : asm_core

// ---- asm_core_tb_top.sv ----
/*
  Self-checking bench for the cipher security module: register port tasks,
  known-answer AES runs in both modes and directions, error and abort cases.
  Assumes asm_defs.svh and asm_pkg with asm_core, one 25 MHz clock.
*/
`timescale 1ns/1ps
`include "asm_defs.svh"

module asm_core_tb_top;
  localparam logic [127:0] KEY = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
  localparam logic [127:0] PT  = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  localparam logic [127:0] CT  = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
  localparam logic [127:0] LRK = 128'h1311_1d7f_e394_4a17_f307_a78b_4d2b_30c5;

  logic              clk_sys;
  logic              reset_n;
  asm_pkg::asm_bus_t bus;
  logic [7:0]        rdata;
  logic              trx_sleep;
  logic              irq;
  int                fail_count;
  int                checks_done;
  int                cyc = 0;
  logic [127:0]      v;
  logic [7:0]        b;

  asm_core dut_u (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .bus       (bus),
    .rdata     (rdata),
    .trx_sleep (trx_sleep),
    .irq       (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Each access leaves one idle cycle so no strobe is driven twice in a step
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic ld16(input logic [8:0] a, input logic [127:0] val);
    for (int i = 0; i < 16; i++) wr(a, val[127-8*i -: 8]);
  endtask : ld16

  task automatic rd16(input logic [8:0] a, output logic [127:0] val);
    logic [7:0] t;
    for (int i = 0; i < 16; i++) begin
      rd(a, t);
      val[127-8*i -: 8] = t;
    end
  endtask : rd16

  // Polls status until an event shows; a hung run ends with status 0
  task automatic wait_st(output logic [7:0] s);
    int n;
    s = 8'h00;
    n = 0;
    while (s === 8'h00 && n < 40) begin
      rd(`ASM_OFF_STATUS, s);
      n++;
    end
  endtask : wait_st

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    fail_count  = 0;
    checks_done = 0;
    reset_n     = 1'b0;
    trx_sleep   = 1'b0;
    bus         = '0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);

    rd(`ASM_OFF_CTRL, b);
    chk("ctrl reset", b, 8'h00);
    rd(`ASM_OFF_STATUS, b);
    chk("status reset", b, 8'h00);
    rd(`ASM_OFF_MASK, b);
    chk("mask reset", b, 8'hFF);
    rd(9'h100, b);
    chk("unmapped", b, 8'h00);
    wr(`ASM_OFF_STATUS, 8'hFF);
    rd(`ASM_OFF_STATUS, b);
    chk("status read only", b, 8'h00);
    rd16(`ASM_OFF_KEY, v);
    chk("key reset", v, 128'h0);
    wr(`ASM_OFF_CTRL, 8'h2C);
    rd(`ASM_OFF_CTRL, b);
    chk("ctrl fields", b, 8'h2C);
    $display("test reset_and_fields done");

    ld16(`ASM_OFF_KEY, KEY);
    ld16(`ASM_OFF_TEXT, PT);
    wr(`ASM_OFF_CTRL, 8'h84);
    // Completion latency is fixed at ten cycles after the start
    repeat (12) @(posedge clk_sys);
    chk("irq on done", irq, 1'b1);
    rd(`ASM_OFF_STATUS, b);
    chk("status done", b, 8'h01);
    @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    rd16(`ASM_OFF_TEXT, v);
    chk("ecb cipher", v, CT);
    rd16(`ASM_OFF_KEY, v);
    chk("last round key", v, LRK);
    ld16(`ASM_OFF_TEXT, PT);
    wr(`ASM_OFF_MASK, 8'h00);
    wr(`ASM_OFF_CTRL, 8'h84);
    // Look at the line before the status read clears the done flag
    repeat (12) @(posedge clk_sys);
    chk("irq masked", irq, 1'b0);
    wait_st(b);
    chk("status masked run", b, 8'h01);
    rd16(`ASM_OFF_TEXT, v);
    chk("key reused", v, CT);
    wr(`ASM_OFF_MASK, 8'hFF);
    $display("test ecb_encrypt done");

    ld16(`ASM_OFF_KEY, LRK);
    ld16(`ASM_OFF_TEXT, CT);
    wr(`ASM_OFF_CTRL, 8'h08);
    wr(`ASM_OFF_CTRL, 8'h88);
    wait_st(b);
    chk("status decrypt", b, 8'h01);
    rd16(`ASM_OFF_TEXT, v);
    chk("ecb plain", v, PT);
    rd16(`ASM_OFF_KEY, v);
    chk("key after decrypt", v, KEY);
    $display("test ecb_decrypt done");

    for (int i = 0; i < 5; i++) wr(`ASM_OFF_TEXT, 8'h5A);
    wr(`ASM_OFF_CTRL, 8'h80);
    wait_st(b);
    chk("partial text", b, 8'h80);
    for (int i = 0; i < 3; i++) wr(`ASM_OFF_KEY, 8'hA5);
    wr(`ASM_OFF_CTRL, 8'h80);
    wait_st(b);
    chk("partial key", b, 8'h80);
    ld16(`ASM_OFF_KEY, KEY);
    ld16(`ASM_OFF_TEXT, PT);
    wr(`ASM_OFF_CTRL, 8'h80);
    rd(`ASM_OFF_CTRL, b);
    wait_st(b);
    chk("abort status", b, 8'h80);
    rd16(`ASM_OFF_TEXT, v);
    chk("abort text kept", v, PT);
    for (int i = 0; i < 4; i++) rd(`ASM_OFF_TEXT, b);
    wr(`ASM_OFF_CTRL, 8'h80);
    wait_st(b);
    chk("partial read", b, 8'h80);
    $display("test errors done");

    wr(`ASM_OFF_MASK, 8'h80);
    wr(`ASM_OFF_TEXT, 8'h5A);
    wr(`ASM_OFF_CTRL, 8'h84);
    chk("irq on error", irq, 1'b1);
    @(posedge clk_sys);
    trx_sleep <= 1'b1;
    repeat (2) @(posedge clk_sys);
    trx_sleep <= 1'b0;
    @(posedge clk_sys);
    chk("sleep irq", irq, 1'b0);
    rd(`ASM_OFF_CTRL, b);
    chk("sleep ctrl", b, 8'h00);
    rd(`ASM_OFF_STATUS, b);
    chk("sleep status", b, 8'h00);
    rd(`ASM_OFF_MASK, b);
    chk("sleep mask", b, 8'hFF);
    rd16(`ASM_OFF_TEXT, v);
    chk("sleep text", v, 128'h0);
    rd16(`ASM_OFF_KEY, v);
    chk("sleep key", v, 128'h0);
    $display("test sleep done");

    // Sleep zeroed the chaining value, so the first chained block acts as code book
    ld16(`ASM_OFF_KEY, KEY);
    ld16(`ASM_OFF_TEXT, PT);
    wr(`ASM_OFF_CTRL, 8'hA0);
    wait_st(b);
    chk("cbc status", b, 8'h01);
    rd16(`ASM_OFF_TEXT, v);
    chk("cbc block one", v, CT);
    ld16(`ASM_OFF_TEXT, CT ^ PT);
    wr(`ASM_OFF_CTRL, 8'hA0);
    wait_st(b);
    chk("cbc status two", b, 8'h01);
    rd16(`ASM_OFF_TEXT, v);
    chk("cbc block two", v, CT);
    // Chained decryption adds the previous cipher block back after the inverse cipher
    ld16(`ASM_OFF_KEY, LRK);
    ld16(`ASM_OFF_TEXT, CT);
    wr(`ASM_OFF_CTRL, 8'hA8);
    wait_st(b);
    chk("cbc decrypt status", b, 8'h01);
    rd16(`ASM_OFF_TEXT, v);
    chk("cbc decrypt", v, CT ^ PT);
    $display("test cbc done");
    test_done();
  end
endmodule : asm_core_tb_top
